/* bench/psc_host.sv */
// Download cable host model that shifts an image into the loader.
`timescale 1ns/1ps
module psc_host (
   // Cable lines
   output logic config_request_n,
   output logic serial_load_clock,
   output logic serial_data
);
   initial begin
      config_request_n = 1'b1;
      serial_load_clock = 1'b0;
      serial_data = 1'b0;
   end
   // pulse request low, then a pause before clocking.
   task automatic restart();
      config_request_n = 1'b0;
      #1000 config_request_n = 1'b1;
      #2000;
   endtask
   // one bit per clock, MSB first; clock idles low between frames.
   task automatic send(input logic [31:0] img, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_data = img[i];
         #200 serial_load_clock = 1'b1;
         #200 serial_load_clock = 1'b0;
      end
      serial_data = ~serial_data; // Stale data must not look valid.
   endtask
endmodule // psc_host

/* bench/psc_loader_bench.sv */
// Self-checking bench for the serial configuration loader.
`timescale 1ns/1ps
module psc_loader_bench;
   logic        clk, rst, ce, req_n, sclk, sdat, cen_n, err;
   logic        st_oe, dn_oe, st_in, dn_in, cen_o_n, um, io_oe, pu, bv;
   logic [3:0]  sel;
   logic [7:0]  cb;
   logic [7:0]  got[$];
   int          err_total, n_compared, cyc;
   // shared lines with pull-ups, one device.
   assign st_in = ~st_oe;
   assign dn_in = ~dn_oe;
   psc_host host_u (.config_request_n(req_n), .serial_load_clock(sclk), .serial_data(sdat));
   psc_loader #(.POR_FAST_CYC(50), .POR_STD_CYC(80), .INIT_CYC(20), .IMAGE_BITS(32)) dut_u (
      .clk(clk), .rst(rst), .ce(ce), .scheme_select(sel), .config_request_n(req_n),
      .serial_load_clock(sclk), .serial_data(sdat), .status_in(st_in), .status_out(),
      .status_oe(st_oe), .done_in(dn_in), .done_out(), .done_oe(dn_oe),
      .chain_enable_in_n(cen_n), .chain_enable_out_n(cen_o_n), .image_error(err),
      .user_mode(um), .user_io_oe(io_oe), .weak_pullup_en(pu), .cfg_byte(cb),
      .cfg_byte_valid(bv));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Bytes are captured as they come, since the valid pulse lasts one cycle.
   always @(posedge clk) begin
      if (bv) got.push_back(cb);
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_por(input logic [3:0] s, input int lo, input int hi);
      @(posedge clk) sel <= s;
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (lo) @(posedge clk);
      #1 chk("status_oe in delay", 1, st_oe);
      chk("user_io_oe", 0, io_oe);
      chk("pullup", 1, pu);
      repeat (hi - lo) @(posedge clk);
      #1 chk("status_oe released", 0, st_oe);
   endtask
   task automatic t_load(input logic [31:0] img);
      got.delete();
      host_u.restart();
      host_u.send(img, 32);
      repeat (4) @(posedge clk);
      #1 chk("byte count", 4, got.size());
      for (int i = 0; i < 4; i++) chk("byte", img[31-8*i -: 8], got[i]);
      chk("done_oe", 0, dn_oe);
      chk("chain out", 0, cen_o_n);
      chk("user before init", 0, um);
      repeat (30) @(posedge clk);
      #1 chk("user mode", 1, um);
      chk("io enabled", 1, io_oe);
   endtask
   task automatic t_err();
      host_u.restart();
      #1 chk("user after reconfig", 0, um);
      chk("done pulled", 1, dn_oe);
      host_u.send(32'h0000_00c3, 8);
      @(posedge clk) err <= 1'b1;
      @(posedge clk) err <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("status after error", 1, st_oe);
      host_u.send(32'hffff_ffff, 32);
      #1 chk("chain after error", 1, cen_o_n);
   endtask
   task automatic t_cen();
      got.delete();
      host_u.restart();
      @(posedge clk) cen_n <= 1'b1;
      host_u.send(32'h1234_5678, 32);
      repeat (4) @(posedge clk);
      #1 chk("ignored bytes", 0, got.size());
      chk("chain out idle", 1, cen_o_n);
      @(posedge clk) cen_n <= 1'b0;
   endtask
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      sel = 4'h0;
      err = 1'b0;
      cen_n = 1'b0;
      t_por(4'h0, 45, 60);
      t_por(4'h1, 75, 90);
      t_load(32'ha5c3_0f96);
      t_err();
      t_cen();
      t_load(32'h3c5a_9601);
      conclude();
   end
endmodule // psc_loader_bench

/* bench/psc_loader_sva.sv */
// Port-level assertions for the serial configuration loader.
`timescale 1ns/1ps
module psc_loader_sva #(
   parameter INIT_CYC = 20
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Pins and status
   input wire config_request_n,
   input wire done_in,
   input wire status_oe,
   input wire done_oe,
   input wire chain_enable_out_n,
   input wire image_error,
   input wire user_mode,
   input wire user_io_oe,
   input wire weak_pullup_en,
   input wire cfg_byte_valid
);
   localparam int INIT_LO = INIT_CYC;
   localparam int INIT_HI = INIT_CYC + 6;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_POR_STATUS: assert property (disable iff (1'b0) $fell(rst) |-> status_oe)
      else $error("status not held low in reset");
   AST_IO_TRI: assert property (!user_mode |-> !user_io_oe)
      else $error("user pins driven before user mode");
   AST_PULLUP: assert property (!user_mode |-> weak_pullup_en)
      else $error("pull-ups off before user mode");
   AST_REQ_RESET: assert property (!config_request_n [*4] |-> status_oe && !user_mode)
      else $error("low request did not hold reset");
   AST_DONE_HOLD: assert property (!done_in |-> !user_mode)
      else $error("user mode while done line low");
   AST_INIT_TIME: assert property ($rose(done_in) |-> ##[INIT_LO:INIT_HI] $rose(user_mode))
      else $error("init time out of range");
   AST_CHAIN_OUT: assert property ($fell(chain_enable_out_n) |-> !done_oe)
      else $error("chain output without done release");
   AST_ERR_HALT: assert property (image_error && !status_oe && done_oe |-> ##[1:4] status_oe)
      else $error("error did not pull status low");
   AST_NO_DATA: assert property (status_oe [*2] |-> !cfg_byte_valid)
      else $error("byte taken while status low");
   cover property ($rose(user_mode));
   cover property ($fell(chain_enable_out_n));
   cover property (cfg_byte_valid);
endmodule // psc_loader_sva

bind psc_loader psc_loader_sva #(.INIT_CYC(INIT_CYC)) sva_u (.clk(clk), .rst(rst),
   .config_request_n(config_request_n), .done_in(done_in), .status_oe(status_oe),
   .done_oe(done_oe), .chain_enable_out_n(chain_enable_out_n), .image_error(image_error),
   .user_mode(user_mode), .user_io_oe(user_io_oe), .weak_pullup_en(weak_pullup_en),
   .cfg_byte_valid(cfg_byte_valid));

/* verilog/psc_defines.vh */
// Constants for the passive serial cable configuration loader.
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
`define PSC_CLK_HZ        20000000
`define PSC_POR_FAST_US   6000
`define PSC_POR_STD_US    100000
`define PSC_INIT_US       400
`define PSC_CYC(us)       (((us) * (`PSC_CLK_HZ / 1000000)))
`define PSC_SEL_STD_BIT   0
`define PSC_IMAGE_BITS    1024
`endif

/* verilog/psc_loader.v */
// Device-side passive serial configuration sequencer with daisy-chain support.
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_loader #(
   parameter POR_FAST_CYC = `PSC_CYC(`PSC_POR_FAST_US),
   parameter POR_STD_CYC  = `PSC_CYC(`PSC_POR_STD_US),
   parameter INIT_CYC     = `PSC_CYC(`PSC_INIT_US),
   parameter IMAGE_BITS   = `PSC_IMAGE_BITS
) (
   // Clock, reset, enable
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   // Straps
   input  wire [3:0]  scheme_select,
   // Host cable lines
   input  wire        config_request_n,
   input  wire        serial_load_clock,
   input  wire        serial_data,
   // Shared open-drain status line
   input  wire        status_in,
   output wire        status_out,
   output wire        status_oe,
   // Shared open-drain done line
   input  wire        done_in,
   output wire        done_out,
   output wire        done_oe,
   // Chain enables
   input  wire        chain_enable_in_n,
   output reg         chain_enable_out_n,
   // Local error report and user side
   input  wire        image_error,
   output reg         user_mode,
   output reg         user_io_oe,
   output reg         weak_pullup_en,
   output reg  [7:0]  cfg_byte,
   output reg         cfg_byte_valid
);
   // Sequencer states.
   localparam [5:0] ST_POR  = 6'h01;
   localparam [5:0] ST_RST  = 6'h02;
   localparam [5:0] ST_CFG  = 6'h04;
   localparam [5:0] ST_WAIT = 6'h08;
   localparam [5:0] ST_INIT = 6'h10;
   localparam [5:0] ST_USER = 6'h20;

   wire [4:0] pins_s;
   wire       req_n_s  = pins_s[0];
   wire       sclk_s   = pins_s[1];
   wire       data_s   = pins_s[2];
   wire       stat_s   = pins_s[3];
   wire       done_s   = pins_s[4];
   wire       cen_n_s;

   reg  [5:0]  state_q;
   reg  [31:0] cnt_q;
   reg  [31:0] por_len_q;
   reg         sclk_prev_q;
   reg  [31:0] bit_cnt_q;
   reg  [2:0]  bit_pos_q;
   reg  [7:0]  shift_q;
   reg         status_low_q;
   reg         done_rel_q;
   reg         err_q;

   wire sclk_rise = sclk_s & ~sclk_prev_q;

   // Every cable, status, done and chain pin passes two flops; scheme_select and image_error are used directly.
   psc_sync #(.W(5)) u_sync (
      .clk      (clk),
      .ce       (ce),
      .pin_in   ({done_in, status_in, serial_data, serial_load_clock, config_request_n}),
      .pin_sync (pins_s)
   );

   psc_sync #(.W(1)) u_sync_ce (
      .clk      (clk),
      .ce       (ce),
      .pin_in   (chain_enable_in_n),
      .pin_sync (cen_n_s)
   );

   // Open-drain lines only ever pull low; enable high means driving low.
   assign status_out = 1'b0;
   assign status_oe  = status_low_q;
   assign done_out   = 1'b0;
   assign done_oe    = ~done_rel_q;

   // Main sequencer. Power-on delay is modelled as the time from rst release.
   always @(posedge clk) begin
      if (rst) begin
         state_q            <= ST_POR;
         cnt_q              <= 32'h0;
         por_len_q          <= 32'h0;
         sclk_prev_q        <= 1'b0;
         bit_cnt_q          <= 32'h0;
         bit_pos_q          <= 3'h0;
         shift_q            <= 8'h00;
         status_low_q       <= 1'b1;
         done_rel_q         <= 1'b0;
         err_q              <= 1'b0;
         chain_enable_out_n <= 1'b1;
         user_mode          <= 1'b0;
         user_io_oe         <= 1'b0;
         weak_pullup_en     <= 1'b1;
         cfg_byte           <= 8'h00;
         cfg_byte_valid     <= 1'b0;
      end else if (ce) begin
         sclk_prev_q    <= sclk_s;
         cfg_byte_valid <= 1'b0;
         case (state_q)
            ST_POR: begin
               // hold reset: status low, pins floating during delay.
               status_low_q <= 1'b1;
               user_io_oe   <= 1'b0;
               // strap picks the delay, caught after reset release.
               if (cnt_q == 32'h0)
                  por_len_q <= scheme_select[`PSC_SEL_STD_BIT] ? POR_STD_CYC : POR_FAST_CYC;
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q != 32'h0 && cnt_q >= por_len_q) begin
                  state_q <= ST_RST;
                  cnt_q   <= 32'h0;
               end
            end
            ST_RST: begin
               // pins stay floating with pull-ups until user mode.
               user_io_oe     <= 1'b0;
               weak_pullup_en <= 1'b1;
               done_rel_q     <= 1'b0;
               bit_cnt_q      <= 32'h0;
               bit_pos_q      <= 3'h0;
               chain_enable_out_n <= 1'b1;
               // release status once request is high, unless an error is pending.
               // A reported error keeps status low until the host drops the request.
               status_low_q <= ~req_n_s | err_q;
               if (!req_n_s)
                  err_q <= 1'b0;
               // stay in reset while request or status is low.
               if (req_n_s && stat_s && !status_low_q)
                  state_q <= ST_CFG;
            end
            ST_CFG: begin
               // local error pulls shared status low.
               if (image_error) begin
                  status_low_q <= 1'b1;
                  err_q        <= 1'b1;
               end
               // a falling request pulls status low at once.
               if (!req_n_s)
                  status_low_q <= 1'b1;
               // chain halts when status or request falls.
               if (!req_n_s || !stat_s || image_error) begin
                  state_q <= ST_RST;
               // take bits on rising edge when enabled.
               end else if (sclk_rise && !cen_n_s && chain_enable_out_n) begin
                  shift_q   <= {shift_q[6:0], data_s};
                  bit_pos_q <= bit_pos_q + 3'h1;
                  bit_cnt_q <= bit_cnt_q + 32'h1;
                  if (bit_pos_q == 3'h7) begin
                     cfg_byte       <= {shift_q[6:0], data_s};
                     cfg_byte_valid <= 1'b1;
                  end
                  // whole image taken: pass the chain along.
                  if (bit_cnt_q == IMAGE_BITS - 1) begin
                     chain_enable_out_n <= 1'b0;
                     done_rel_q         <= 1'b1;
                     state_q            <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               // wait for the shared done line to rise.
               cnt_q <= 32'h0;
               if (!req_n_s)
                  status_low_q <= 1'b1;
               if (!req_n_s || !stat_s)
                  state_q <= ST_RST;
               else if (done_s)
                  state_q <= ST_INIT;
            end
            ST_INIT: begin
               // initialise on own clock for the fixed delay.
               cnt_q <= cnt_q + 32'h1;
               if (!req_n_s) begin
                  state_q      <= ST_RST;
                  status_low_q <= 1'b1;
               end else if (cnt_q >= INIT_CYC - 1) begin
                  state_q        <= ST_USER;
                  user_mode      <= 1'b1;
                  user_io_oe     <= 1'b1;
                  weak_pullup_en <= 1'b0;
               end
            end
            ST_USER: begin
               // a low request starts a fresh reconfiguration.
               if (!req_n_s) begin
                  state_q        <= ST_RST;
                  user_mode      <= 1'b0;
                  user_io_oe     <= 1'b0;
                  weak_pullup_en <= 1'b1;
                  status_low_q   <= 1'b1;
               end
            end
            default: state_q <= ST_POR;
         endcase
      end
   end
endmodule // psc_loader

/* verilog/psc_sync.v */
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module psc_sync #(
   parameter W = 1
) (
   // Clock and enable
   input  wire         clk,
   input  wire         ce,
   // Pins in, synchronised out
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] pin_sync
);
   reg [W-1:0] meta_q;

   // First stage feeds only the second stage.
   always @(posedge clk) begin
      if (ce) begin
         meta_q   <= pin_in;
         pin_sync <= meta_q;
      end
   end
endmodule // psc_sync
